/* verilog/tro_pkg.sv */
// Constants and types for the triggered output port.
// Assumes an APB slave with 32-bit data and one word per register.
package tro_pkg;

    // ==================================================
    // Register map
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_BUF_LOW  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BUF_HIGH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DIR      = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LATCH    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PINS     = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h1C;

    // ==================================================
    // Widths, fields and reset values
    localparam int unsigned PORT_W = 8;
    localparam int unsigned NIB_W  = 4;
    localparam int unsigned CTRL_EXT_BIT  = 0;
    localparam int unsigned CTRL_BYTE_BIT = 1;
    localparam int unsigned STAT_LOW_BIT  = 0;
    localparam int unsigned STAT_HIGH_BIT = 1;
    localparam logic [7:0] DIR_RESET   = 8'hFF;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] BUF_RESET   = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ==================================================
    // Carriers
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } tro_apb_req_t;

    typedef struct packed {
        logic byte_mode;
        logic external_trigger_select;
    } tro_ctrl_t;

    typedef struct packed {
        logic timer_one_match_request;
        logic timer_two_match_request;
        logic external_pin_interrupt;
    } tro_trig_t;

endpackage : tro_pkg

/* verilog/tro_out_latch.sv */
// Output latch of the port pins.
// Assumes one clock, an active-low async reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module tro_out_latch
    import tro_pkg::*;
#(
    parameter int unsigned WIDTH = PORT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             sw_we,
    input  wire logic [WIDTH-1:0] sw_data,
    input  wire logic [WIDTH-1:0] rt_mask,
    input  wire logic [WIDTH-1:0] load_mask,
    input  wire logic [WIDTH-1:0] buf_data,
    output var  logic [WIDTH-1:0] latch_q
);

    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] sw_mask;
    logic [WIDTH-1:0] hw_mask;

    // ==================================================
    // Next latch value
    always_comb begin
        sw_mask = sw_we ? ~rt_mask : '0;      // R08
        hw_mask = load_mask & rt_mask;        // R12
        latch_d = (latch_q & ~sw_mask & ~hw_mask)
                | (sw_data & sw_mask)
                | (buf_data & hw_mask);       // R11
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= LATCH_RESET[WIDTH-1:0];
        end else if (clk_en) begin
            latch_q <= latch_d;
        end
    end

endmodule : tro_out_latch
`default_nettype wire

/* verilog/tro_port.sv */
// Triggered output port: buffered pattern copied to the pin latch
// by timer match or external pin trigger, with an APB register file.
// Assumes triggers and pin inputs synchronous to pclk.
//
// How it works
// (R01) Nibble mode: low buffer write sets low nibble, high sets high.
// (R02) Byte mode: write to either buffer loads both nibbles.
// (R03) Buffer read gives high nibble on top, low nibble below.
// (R04) Buffer read shows only real-time bits; port-mode bits read zero.
// (R05) Software fills the buffer before the selected trigger arrives.
// (R06) Direction bits reset to all ones; zero makes a pin an output.
// (R07) Mode-select chooses real-time or port per bit; resets to zero.
// (R08) Latch writes skip real-time bits; preload latch before switching.
// (R09) Nibble mode trigger choice per external-trigger bit.
// (R10) Byte mode: all bits on timer one or external pin; ctrl resets 0.
// (R11) Selected trigger copies buffer into latch in the same cycle.
// (R12) Trigger copy touches only real-time bits of the latch.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module tro_port
    import tro_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pclk_en,
    input  wire tro_apb_req_t       apb_req,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire tro_trig_t          trig,
    input  wire logic [PORT_W-1:0]  port_twelve_pins_i,
    output var  logic [PORT_W-1:0]  port_twelve_pins_o,
    output var  logic [PORT_W-1:0]  port_twelve_pins_oe
);

    // ==================================================
    // Functions
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        addr_hit = (a == off);
    endfunction : addr_hit

    function automatic logic [31:0] widen(input logic [7:0] v);
        widen = {24'h00_0000, v};
    endfunction : widen

    // ==================================================
    // State
    logic [NIB_W-1:0]  buf_low_q;
    logic [NIB_W-1:0]  buf_low_d;
    logic [NIB_W-1:0]  buf_high_q;
    logic [NIB_W-1:0]  buf_high_d;
    logic [PORT_W-1:0] dir_q;
    logic [PORT_W-1:0] dir_d;
    logic [PORT_W-1:0] mode_q;
    logic [PORT_W-1:0] mode_d;
    tro_ctrl_t         ctrl_q;
    tro_ctrl_t         ctrl_d;
    logic [1:0]        stat_q;
    logic [1:0]        stat_d;
    logic [31:0]       prdata_q;
    logic [31:0]       prdata_d;
    logic              pready_q;
    logic              pready_d;
    logic              pslverr_q;
    logic              pslverr_d;

    // ==================================================
    // Bus decode
    logic              setup;
    logic              wr_done;
    logic              mapped;
    logic              wr_low;
    logic              wr_high;
    logic              wr_latch;
    logic [7:0]        wdat;

    always_comb begin
        setup   = apb_req.psel & ~apb_req.penable;
        wr_done = apb_req.psel & apb_req.penable & pready_q
                & apb_req.pwrite & ~pslverr_q;
        mapped  = addr_hit(apb_req.paddr, OFF_BUF_LOW)
                | addr_hit(apb_req.paddr, OFF_BUF_HIGH)
                | addr_hit(apb_req.paddr, OFF_DIR)
                | addr_hit(apb_req.paddr, OFF_MODE)
                | addr_hit(apb_req.paddr, OFF_CTRL)
                | addr_hit(apb_req.paddr, OFF_LATCH)
                | addr_hit(apb_req.paddr, OFF_PINS)
                | addr_hit(apb_req.paddr, OFF_STATUS);
        wr_low   = wr_done & addr_hit(apb_req.paddr, OFF_BUF_LOW);
        wr_high  = wr_done & addr_hit(apb_req.paddr, OFF_BUF_HIGH);
        wr_latch = wr_done & addr_hit(apb_req.paddr, OFF_LATCH);
        wdat     = apb_req.pwdata[7:0];
    end

    // ==================================================
    // Trigger selection
    logic fire_low;
    logic fire_high;
    logic [PORT_W-1:0] load_mask;

    always_comb begin
        if (ctrl_q.byte_mode) begin
            fire_low = ctrl_q.external_trigger_select
                     ? trig.external_pin_interrupt
                     : trig.timer_one_match_request;    // R10
            fire_high = fire_low;                        // R10
        end else if (ctrl_q.external_trigger_select) begin
            fire_high = trig.timer_one_match_request;    // R09
            fire_low  = trig.external_pin_interrupt;     // R09
        end else begin
            fire_high = trig.timer_two_match_request;    // R09
            fire_low  = trig.timer_one_match_request;    // R09
        end
        load_mask = {{NIB_W{fire_high}}, {NIB_W{fire_low}}};
    end

    // ==================================================
    // Buffer registers
    always_comb begin
        buf_low_d  = buf_low_q;
        buf_high_d = buf_high_q;
        if (ctrl_q.byte_mode) begin
            if (wr_low | wr_high) begin
                buf_low_d  = wdat[NIB_W-1:0];           // R02
                buf_high_d = wdat[PORT_W-1:NIB_W];      // R02
            end
        end else begin
            if (wr_low) begin
                buf_low_d = wdat[NIB_W-1:0];            // R01
            end
            if (wr_high) begin
                buf_high_d = wdat[PORT_W-1:NIB_W];      // R01
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_low_q  <= BUF_RESET[NIB_W-1:0];
            buf_high_q <= BUF_RESET[PORT_W-1:NIB_W];
        end else if (pclk_en) begin
            buf_low_q  <= buf_low_d;
            buf_high_q <= buf_high_d;
        end
    end

    // ==================================================
    // Control registers
    always_comb begin
        dir_d  = dir_q;
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        if (wr_done & addr_hit(apb_req.paddr, OFF_DIR)) begin
            dir_d = wdat;                                // R06
        end
        if (wr_done & addr_hit(apb_req.paddr, OFF_MODE)) begin
            mode_d = wdat;                               // R07
        end
        if (wr_done & addr_hit(apb_req.paddr, OFF_CTRL)) begin
            ctrl_d.byte_mode = wdat[CTRL_BYTE_BIT];
            ctrl_d.external_trigger_select = wdat[CTRL_EXT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q  <= DIR_RESET;                         // R06
            mode_q <= MODE_RESET;                        // R07
            ctrl_q <= '0;                                // R10
        end else if (pclk_en) begin
            dir_q  <= dir_d;
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ==================================================
    // Consumed flags: set by a transfer, cleared by a refill
    // A transfer in the same cycle as the refill wins.
    always_comb begin
        stat_d = stat_q;
        if (wr_low | (ctrl_q.byte_mode & wr_high)) begin
            stat_d[STAT_LOW_BIT] = 1'b0;
        end
        if (wr_high | (ctrl_q.byte_mode & wr_low)) begin
            stat_d[STAT_HIGH_BIT] = 1'b0;
        end
        if (fire_low) begin
            stat_d[STAT_LOW_BIT] = 1'b1;
        end
        if (fire_high) begin
            stat_d[STAT_HIGH_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 2'b00;
        end else if (pclk_en) begin
            stat_q <= stat_d;
        end
    end

    // ==================================================
    // Output latch
    logic [PORT_W-1:0] latch_q;

    tro_out_latch #(
        .WIDTH (PORT_W)
    ) u_latch (
        .clk       (pclk),
        .rst_n     (presetn),
        .clk_en    (pclk_en),
        .sw_we     (wr_latch),                       // R08
        .sw_data   (wdat),
        .rt_mask   (mode_q),                         // R12
        .load_mask (load_mask),                      // R11
        .buf_data  ({buf_high_q, buf_low_q}),
        .latch_q   (latch_q)
    );

    // ==================================================
    // Pin drive
    logic [PORT_W-1:0] oe_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= ~DIR_RESET;
        end else if (pclk_en) begin
            oe_q <= ~dir_d;                          // R06
        end
    end

    // ==================================================
    // Read data and handshake
    always_comb begin
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup) begin
            pready_d  = 1'b1;
            pslverr_d = ~mapped;
            prdata_d  = RDATA_ZERO;
            if (!apb_req.pwrite) begin
                case (apb_req.paddr)
                    OFF_BUF_LOW, OFF_BUF_HIGH: begin
                        prdata_d = widen({buf_high_q, buf_low_q}
                                         & mode_q);      // R03 R04
                    end
                    OFF_DIR: begin
                        prdata_d = widen(dir_q);
                    end
                    OFF_MODE: begin
                        prdata_d = widen(mode_q);
                    end
                    OFF_CTRL: begin
                        prdata_d = widen({6'b00_0000,
                                          ctrl_q.byte_mode,
                                          ctrl_q.external_trigger_select});
                    end
                    OFF_LATCH: begin
                        prdata_d = widen(latch_q);
                    end
                    OFF_PINS: begin
                        prdata_d = widen(port_twelve_pins_i);
                    end
                    OFF_STATUS: begin
                        prdata_d = widen({6'b00_0000, stat_q});
                    end
                    default: begin
                        prdata_d = RDATA_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= RDATA_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (pclk_en) begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==================================================
    // Outputs
    always_comb begin
        prdata              = prdata_q;
        pready              = pready_q;
        pslverr             = pslverr_q;
        port_twelve_pins_o  = latch_q;
        port_twelve_pins_oe = oe_q;
    end

endmodule : tro_port
`default_nettype wire

/* tb/tro_port_asserts.sv */
// Checker for the triggered output port, bound to its top module.
// Assumes one clock domain and a small shadow of mode and control.
`timescale 1ns/1ps
`default_nettype none
module tro_port_asserts
    import tro_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              pclk_en,
    input wire tro_apb_req_t      apb_req,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire tro_trig_t         trig,
    input wire logic [PORT_W-1:0] port_twelve_pins_i,
    input wire logic [PORT_W-1:0] port_twelve_pins_o,
    input wire logic [PORT_W-1:0] port_twelve_pins_oe
);
    // ==================================================
    // Shadow state
    logic [7:0] mode_q, mode_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic       setup, wr, lw, lo, hi;
    always_comb begin
        setup = apb_req.psel && !apb_req.penable && pclk_en;
        wr = apb_req.psel && apb_req.penable && pready && pclk_en
             && apb_req.pwrite;
        lw = wr && apb_req.paddr == OFF_LATCH;
        mode_d = (wr && apb_req.paddr == OFF_MODE) ?
                 apb_req.pwdata[7:0] : mode_q;
        ctrl_d = (wr && apb_req.paddr == OFF_CTRL) ?
                 apb_req.pwdata[1:0] : ctrl_q;
        lo = pclk_en && (ctrl_q[0] ? trig.external_pin_interrupt
                                   : trig.timer_one_match_request);
        hi = pclk_en && (ctrl_q[1] ? lo : (ctrl_q[0] ?
             trig.timer_one_match_request : trig.timer_two_match_request));
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 8'h00;
            ctrl_q <= 2'h0;
        end else begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
        end
    end
    // ==================================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_pins_idle: assert property (
        $rose(presetn) |-> port_twelve_pins_oe == 8'h00
        && port_twelve_pins_o == 8'h00) else $error("pins not idle");
    a_oe_follows_dir: assert property (
        wr && apb_req.paddr == OFF_DIR |=> port_twelve_pins_oe ==
        ~$past(apb_req.pwdata[7:0])) else $error("oe not inverse dir");
    a_buf_read_mask: assert property (
        setup && !apb_req.pwrite && (apb_req.paddr == OFF_BUF_LOW ||
        apb_req.paddr == OFF_BUF_HIGH) |=> (prdata[7:0] &
        ~$past(mode_q)) == 8'h00) else $error("port bit read not zero");
    a_latch_skip_rt: assert property (
        lw && !lo && !hi |=> ((port_twelve_pins_o ^
        $past(port_twelve_pins_o)) & $past(mode_q)) == 8'h00)
        else $error("latch write hit rt bit");
    a_latch_port_bits: assert property (
        lw |=> ((port_twelve_pins_o ^ $past(apb_req.pwdata[7:0])) &
        ~$past(mode_q)) == 8'h00) else $error("latch write lost");
    a_trig_port_keep: assert property (
        (lo || hi) && !lw |=> ((port_twelve_pins_o ^
        $past(port_twelve_pins_o)) & ~$past(mode_q)) == 8'h00)
        else $error("trigger hit port bit");
    a_unselected_hold: assert property (
        !lo && !hi && !lw |=> $stable(port_twelve_pins_o))
        else $error("pins moved without cause");
    a_low_only: assert property (
        lo && !hi && !lw |=> port_twelve_pins_o[7:4] ==
        $past(port_twelve_pins_o[7:4])) else $error("high nibble moved");
    a_high_only: assert property (
        hi && !lo && !lw |=> port_twelve_pins_o[3:0] ==
        $past(port_twelve_pins_o[3:0])) else $error("low nibble moved");
    c_low_trig: cover property (lo && !hi);
    c_byte_trig: cover property (lo && hi && ctrl_q[1]);
    c_bad_addr: cover property (pready && pslverr);
endmodule : tro_port_asserts
bind tro_port tro_port_asserts i_tro_port_asserts (.pclk, .presetn,
    .pclk_en, .apb_req, .prdata, .pready, .pslverr, .trig,
    .port_twelve_pins_i, .port_twelve_pins_o, .port_twelve_pins_oe);
`default_nettype wire

/* tb/tro_actuator.sv */
// Actuator model on the port pins.
// Assumes pins not driven by the port float and wander each cycle.
`timescale 1ns/1ps
`default_nettype none
module tro_actuator
    import tro_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic [PORT_W-1:0] drive_val,
    input  wire logic [PORT_W-1:0] drive_en,
    output var  logic [PORT_W-1:0] pin_level
);
    logic [PORT_W-1:0] float_q = 8'h55;
    always @(posedge pclk) begin
        float_q <= ~float_q;
    end
    // Only pins whose direction is output carry the latch value
    always_comb begin
        pin_level = (drive_val & drive_en) | (float_q & ~drive_en);
    end
endmodule : tro_actuator
`default_nettype wire

/* tb/tb_tro_port.sv */
// Self-checking bench for the triggered output port.
// Assumes APB answers within a few cycles and triggers are pulses.
`timescale 1ns/1ps
`default_nettype none
module tb_tro_port;
    import tro_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         pclk_en = 1'b1;
    tro_apb_req_t req = '0;
    tro_trig_t    trig = '0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, er, lo, hi;
    logic [7:0]   pins_i, pins_o, pins_oe, lat, p, m, ba;
    int           fail_count = 0;
    int           n_compared = 0;

    always #25 pclk = ~pclk;

    tro_port i_tro_port (.pclk, .presetn, .pclk_en, .apb_req(req),
        .prdata, .pready, .pslverr, .trig, .port_twelve_pins_i(pins_i),
        .port_twelve_pins_o(pins_o), .port_twelve_pins_oe(pins_oe));
    tro_actuator i_tro_actuator (.pclk, .drive_val(pins_o),
        .drive_en(pins_oe), .pin_level(pins_i));

    // ==================================================
    // Tasks
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) fail_count++;
        rd = prdata;
        er = pslverr;
        req <= '0;
    endtask : apb

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    // ==================================================
    // Tests
    initial begin
        #(3000 * 50);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_DIR, 32'h0);
        chk("dir", 32'h0000_00FF, rd);
        chk("oe", 32'h0000_0000, {24'h0, pins_oe});
        apb(1'b0, OFF_MODE, 32'h0);
        chk("mode", 32'h0000_0000, rd);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0000, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0000_0001, {31'h0, er});
        chk("unmapped data", 32'h0000_0000, rd);
        $display("test reset done");
        apb(1'b1, OFF_LATCH, 32'h0000_00A5);
        apb(1'b1, OFF_DIR, 32'h0);
        apb(1'b1, OFF_MODE, 32'h0000_00F3);
        apb(1'b1, OFF_LATCH, 32'h0);
        @(negedge pclk);
        chk("latch", 32'h0000_00A1, {24'h0, pins_o});
        chk("oe", 32'h0000_00FF, {24'h0, pins_oe});
        lat = 8'hA1;
        $display("test latch done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFF_CTRL, 32'(c));
            for (int t = 0; t < 3; t++) begin
                p = 8'h5A + 8'(c * 3 + t) * 8'h11;
                if (c[1]) begin
                    ba = t[0] ? OFF_BUF_HIGH : OFF_BUF_LOW;
                    apb(1'b1, ba, {24'h0, p});
                end else begin
                    apb(1'b1, OFF_BUF_LOW, {24'h0, p ^ 8'hF0});
                    apb(1'b1, OFF_BUF_HIGH, {24'h0, p ^ 8'h0F});
                end
                apb(1'b0, t[0] ? OFF_BUF_LOW : OFF_BUF_HIGH, 32'h0);
                chk("buffer", {24'h0, p & 8'hF3}, rd);
                @(posedge pclk);
                trig <= tro_trig_t'(3'(4 >> t));
                @(posedge pclk);
                trig <= '0;
                lo = c[0] ? (t == 2) : (t == 0);
                hi = c[1] ? lo : (c[0] ? (t == 0) : (t == 1));
                m = {{4{hi}}, {4{lo}}} & 8'hF3;
                lat = (lat & ~m) | (p & m);
                @(negedge pclk);
                chk("pins", {24'h0, lat}, {24'h0, pins_o});
            end
        end
        apb(1'b0, OFF_PINS, 32'h0);
        chk("pin levels", {24'h0, lat}, rd);
        $display("test triggers done");
        apb(1'b1, OFF_BUF_LOW, 32'h0000_003C);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status cleared", 32'h0000_0000, rd);
        pclk_en <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            trig <= tro_trig_t'(3'b001);
            @(posedge pclk);
            trig    <= '0;
            pclk_en <= 1'b1;
            if (e == 1) lat = (lat & 8'h0C) | (8'h3C & 8'hF3);
            @(negedge pclk);
            chk("pins", {24'h0, lat}, {24'h0, pins_o});
            @(posedge pclk);
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status set", 32'h0000_0003, rd);
        $display("test enable done");
        wrap_up();
    end
endmodule : tb_tro_port
`default_nettype wire
